//--- hw/sipo_regs.svh
// width, buffer depth and reset values for the serial-in parallel-out latch
`ifndef SIPO_REGS_SVH
`define SIPO_REGS_SVH
`define SIPO_WIDTH 8
`define SIPO_SHIFT_RST 8'h00
`define SIPO_STORE_RST 8'h00
`define SIPO_BUF_DEPTH 2
`endif

//--- hw/sipo_pkg.sv
// types shared by the serial-in parallel-out latch
`include "sipo_regs.svh"
package sipo_pkg;
    typedef logic [`SIPO_WIDTH-1:0] sipo_word_t;
endpackage

//--- hw/sipo_buf.sv
// two-entry valid/ready buffer for stored words
`timescale 1ns/100ps
module sipo_buf
    import sipo_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [0:1];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 2'h1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // sipo_buf

//--- hw/sipo_latch.sv
// serial-in parallel-out shift register with storage register and enables
// Notes on behaviour
// - eight-stage shift feeding eight-bit storage register
// - separate shift and storage clocks, rising edges
// - enable low drives outputs, high floats them
// - low clear zeroes shift register, overrides shifting
// - shift edge takes serial input, stages advance
// - storage edge loads all stages in parallel, unless clear is low
// - coinciding edges store pre-shift contents
// - tied clocks give storage one pulse lag
// - last stage drives cascade serial output
`timescale 1ns/100ps
`include "sipo_regs.svh"
module sipo_latch
    import sipo_pkg::*;
#(
    parameter int WIDTH = `SIPO_WIDTH
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic serial_in,
    input wire logic shift_clk,
    input wire logic shift_clear_n,
    input wire logic store_clk,
    input wire logic out_enable_n,
    output logic [WIDTH-1:0] parallel_out,
    output logic [WIDTH-1:0] parallel_oe,
    output logic cascade_out,
    output logic word_valid,
    input wire logic word_ready,
    output logic [WIDTH-1:0] word_data
);
    // three-stage synchronisers; change counts when stages two and three agree
    logic [2:0] ser_s_q;
    logic [2:0] sclk_s_q;
    logic [2:0] clr_s_q;
    logic [2:0] stclk_s_q;
    logic [2:0] oe_s_q;
    logic ser_q;
    logic sclk_q;
    logic clr_n_q;
    logic stclk_q;
    logic oe_n_q;
    logic [WIDTH-1:0] shift_q;
    logic [WIDTH-1:0] store_q;
    logic shift_rise;
    logic store_rise;
    logic store_push;

    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // serial data lags the clock path one cycle, giving hold margin
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ser_s_q <= 3'h0;
            ser_q <= 1'b0;
        end
        else
        begin
            ser_s_q <= {ser_s_q[1:0], serial_in};
            ser_q <= filt(ser_s_q, ser_q);
        end
    end

    // shift clock pin; idles low so reset gives no false edge
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sclk_s_q <= 3'h0;
            sclk_q <= 1'b0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], shift_clk};
            sclk_q <= filt(sclk_s_q, sclk_q);
        end
    end

    // clear pin; idles high so reset gives no false clear
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clr_s_q <= 3'h7;
            clr_n_q <= 1'b1;
        end
        else
        begin
            clr_s_q <= {clr_s_q[1:0], shift_clear_n};
            clr_n_q <= filt(clr_s_q, clr_n_q);
        end
    end

    // storage clock pin
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            stclk_s_q <= 3'h0;
            stclk_q <= 1'b0;
        end
        else
        begin
            stclk_s_q <= {stclk_s_q[1:0], store_clk};
            stclk_q <= filt(stclk_s_q, stclk_q);
        end
    end

    // enable pin; idles high so outputs float after reset
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            oe_s_q <= 3'h7;
            oe_n_q <= 1'b1;
        end
        else
        begin
            oe_s_q <= {oe_s_q[1:0], out_enable_n};
            oe_n_q <= filt(oe_s_q, oe_n_q);
        end
    end

    assign shift_rise = !sclk_q && filt(sclk_s_q, sclk_q);
    assign store_rise = !stclk_q && filt(stclk_s_q, stclk_q);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            shift_q <= `SIPO_SHIFT_RST;
        end
        else if (!clr_n_q)
        begin
            shift_q <= `SIPO_SHIFT_RST;
        end
        else if (shift_rise)
        begin
            shift_q <= {shift_q[WIDTH-2:0], ser_q};
        end
    end

    assign store_push = store_rise && clr_n_q;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            store_q <= `SIPO_STORE_RST;
        end
        // old shift value seen on shared edge
        else if (store_push)
        begin
            store_q <= shift_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            parallel_out <= `SIPO_STORE_RST;
        end
        else
        begin
            // same edge as store_q, so pins never lag storage
            parallel_out <= store_push ? shift_q : store_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            parallel_oe <= '0;
        end
        else
        begin
            parallel_oe <= {WIDTH{!oe_n_q}};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cascade_out <= 1'b0;
        end
        else
        begin
            cascade_out <= shift_q[WIDTH-1];
        end
    end

    // words stored while full are dropped; the pins still update
    sipo_buf #(
        .WIDTH(WIDTH)
    ) u_buf (
        .mclk(mclk),
        .srst(srst),
        .in_valid(store_push),
        .in_ready(),
        .in_data(shift_q),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule // sipo_latch

//--- test/sipo_host.sv
// host model driving the latch pins
`timescale 1ns/100ps
module sipo_host (
    input logic mclk,
    output logic serial_in,
    output logic shift_clk,
    output logic store_clk,
    output logic shift_clear_n,
    output logic out_enable_n
);
    initial {serial_in, shift_clk, store_clk, shift_clear_n, out_enable_n} = 5'h03;
    // one pulse, data flipped once low
    task clk(input logic sh, st);
        {shift_clk, store_clk} <= {sh, st};
        repeat (4) @(negedge mclk);
        {shift_clk, store_clk, serial_in} <= {2'h0, ~serial_in};
        repeat (4) @(negedge mclk);
    endtask
    task put(input logic b, st);
        serial_in <= b;
        repeat (4) @(negedge mclk);
        clk(1'h1, st);
    endtask
endmodule // sipo_host

//--- test/sipo_latch_checker.sv
// port assertions for the latch
`timescale 1ns/100ps
module sipo_chk (
    input logic mclk,
    input logic srst,
    input logic shift_clk,
    input logic shift_clear_n,
    input logic store_clk,
    input logic out_enable_n,
    input logic [7:0] parallel_out,
    input logic [7:0] parallel_oe,
    input logic cascade_out,
    input logic word_valid,
    input logic word_ready,
    input logic [7:0] word_data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    oe_on_a: assert property (!out_enable_n [*8] |-> &parallel_oe) else $error("oe");
    oe_off_a: assert property (out_enable_n [*8] |-> !parallel_oe) else $error("oe");
    clr_zero_a: assert property (!shift_clear_n [*8] |-> !cascade_out) else $error("clr");
    clr_keep_a:
    assert property (!shift_clear_n [*8] |-> $stable(parallel_out)) else $error("clr");
    store_only_a:
    assert property ($stable(store_clk) [*8] |-> $stable(parallel_out)) else $error("st");
    shift_only_a:
    assert property ((shift_clear_n && $stable(shift_clk)) [*8] |-> $stable(cascade_out))
        else $error("co");
    buf_hold_a:
    assert property (word_valid && !word_ready |=> $stable(word_data)) else $error("buf");
    rst_vals_a:
    assert property ($fell(srst) |-> !parallel_oe && !parallel_out && !cascade_out && !word_valid)
        else $error("rst");
    cover property ($rose(word_valid));
    cover property (word_valid && !word_ready);
    cover property ($fell(cascade_out));
endmodule // sipo_chk
bind sipo_latch sipo_chk chk_u (.*);

//--- test/sipo_latch_tb.sv
// self-checking bench for the latch
`timescale 1ns/100ps
module sipo_latch_tb;
    import sipo_pkg::*;
    logic mclk, srst, word_ready, serial_in, shift_clk, store_clk, shift_clear_n, out_enable_n;
    logic cascade_out, word_valid;
    sipo_word_t parallel_out, parallel_oe, word_data;
    int fails, n_tests;
    // word, enable_n, enables expected
    logic [16:0] rows [4] = '{{8'hA5, 9'h0FF}, {8'h3C, 9'h100}, {8'h7E, 9'h0FF}, {8'h81, 9'h100}};
    sipo_host host_u (.*);
    sipo_latch dut_u (.*);
    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task chk(input string n, input logic [7:0] e, s);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task wrap_up;
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {srst, word_ready} = 2'h2;
        repeat (12) @(negedge mclk);
        srst <= 1'h0;
        foreach (rows[i])
        begin
            host_u.out_enable_n <= rows[i][8];
            for (int b = 7; b >= 0; b--)
                host_u.put(rows[i][9 + b], 1'h0);
            host_u.clk(1'h0, 1'h1);
            chk("po", rows[i][16:9], parallel_out);
            chk("oe", rows[i][7:0], parallel_oe);
            chk("co", {7'h0, rows[i][16]}, {7'h0, cascade_out});
        end
        // stalled sink: full buffer kept the oldest two
        chk("wv", 8'h01, {7'h0, word_valid});
        chk("wd", 8'hA5, word_data);
        word_ready <= 1'h1;
        @(negedge mclk);
        word_ready <= 1'h0;
        chk("wd", 8'h3C, word_data);
        chk("wv", 8'h01, {7'h0, word_valid});
        host_u.shift_clear_n <= 1'h0;
        repeat (10) @(negedge mclk);
        chk("co", 8'h00, {7'h0, cascade_out});
        host_u.put(1'h1, 1'h0);
        host_u.clk(1'h0, 1'h1);
        chk("po", 8'h81, parallel_out);
        host_u.shift_clear_n <= 1'h1;
        host_u.put(1'h1, 1'h1);
        chk("po", 8'h00, parallel_out);
        host_u.put(1'h0, 1'h1);
        chk("po", 8'h01, parallel_out);
        // mid-run reset, then one shift and one store
        srst <= 1'h1;
        repeat (2) @(negedge mclk);
        chk("po", 8'h00, parallel_out);
        chk("oe", 8'h00, parallel_oe);
        chk("wv", 8'h00, {7'h0, word_valid});
        srst <= 1'h0;
        host_u.put(1'h1, 1'h0);
        host_u.clk(1'h0, 1'h1);
        chk("po", 8'h01, parallel_out);
        wrap_up();
    end
endmodule // sipo_latch_tb
